// ### mlsc_top.sv
`timescale 1ns/10ps
module mlsc_top #(
  parameter int INIT_CYCLES = mlsc_pkg::INIT_CYCLES,
  parameter int RESET_MIN_CYCLES = mlsc_pkg::RESET_MIN_CYCLES,
  parameter int PW = 8
) (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic DEVICE_SELECT_N_I,
  input wire logic MODULE_RESET_N_I,
  input wire logic LOW_POWER_REQUEST_I,
  input wire logic TRANSMIT_DISABLE_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic [mlsc_pkg::LANES*PW-1:0] RX_POWER_I,
  output logic RECEIVE_SIGNAL_LOST_O,
  output logic IRQ_N_O,
  output logic IRQ_N_OE_O,
  output logic PRESENT_N_O,
  output logic [mlsc_pkg::LANES-1:0] TX_OFF_O,
  output logic LOW_POWER_O
);
  typedef enum logic [2:0] {
    IDLE, ADDR, ACK_ADDR, WPTR, ACK_W, WDATA, RDATA, ACK_R
  } mlsc_st_t;

  typedef struct packed {
    logic [1:0] sel_s;
    logic [1:0] mrst_s;
    logic [1:0] txd_s;
    logic [1:0] lp_s;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    mlsc_st_t st;
    logic [3:0] cnt;
    logic byte_rdy;
    logic rw;
    logic nack;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic sda_oe;
    logic [3:0] tx_soft;
    logic not_ready;
    logic [31:0] init_cnt;
    logic [3:0] los;
    logic [3:0] los_flag;
    logic done_flag;
    logic irq;
    logic los_out;
    logic [3:0] tx_off;
    logic low_pwr;
  } mlsc_state_t;

  mlsc_state_t s_reg;
  mlsc_state_t s_next;
  logic soft_rst;
  logic [3:0] los_now;

  mlsc_reset_filter #(
    .MIN_CYCLES(RESET_MIN_CYCLES)
  ) u_flt (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .level_n_i(s_reg.mrst_s[1]),
    .fire_o(soft_rst)
  );

  function automatic logic [7:0] lane_pwr(input logic [1:0] lane);
    lane_pwr = 8'(RX_POWER_I[lane*PW +: PW]);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [7:0] rd;
    s_next = s_reg;
    scl_rise = s_reg.scl_s[1] && !s_reg.scl_s[2];
    scl_fall = !s_reg.scl_s[1] && s_reg.scl_s[2];
    start = s_reg.scl_s[1] && s_reg.scl_s[2] && !s_reg.sda_s[1]
      && s_reg.sda_s[2];
    stop = s_reg.scl_s[1] && s_reg.scl_s[2] && s_reg.sda_s[1]
      && !s_reg.sda_s[2];
    rd = 8'h00;
    // Pin synchronisers
    s_next.sel_s = {s_reg.sel_s[0], DEVICE_SELECT_N_I};
    s_next.mrst_s = {s_reg.mrst_s[0], MODULE_RESET_N_I};
    s_next.txd_s = {s_reg.txd_s[0], TRANSMIT_DISABLE_I};
    s_next.lp_s = {s_reg.lp_s[0], LOW_POWER_REQUEST_I};
    s_next.scl_s = {s_reg.scl_s[1:0], SCL_I};
    s_next.sda_s = {s_reg.sda_s[1:0], SDA_I};
    // Loss detect per lane
    for (int i = 0; i < mlsc_pkg::LANES; i++)
      los_now[i] = lane_pwr(2'(i)) < mlsc_pkg::LOS_THRESHOLD;
    s_next.los = los_now;
    // Alarm output follows the lanes live, reads never clear it
    s_next.los_out = |los_now;
    // Init timer: runs after power-up and after a filtered reset
    if (s_reg.not_ready)
    begin
      if (s_reg.init_cnt >= 32'(INIT_CYCLES - 1))
      begin
        s_next.not_ready = 1'b0;
        s_next.done_flag = 1'b1;
      end
      else
        s_next.init_cnt = s_reg.init_cnt + 32'h1;
    end
    // Serial slave
    case (s_reg.st)
      IDLE:
        s_next.sda_oe = 1'b0;
      ADDR, WPTR, WDATA:
        if (scl_rise)
        begin
          s_next.shift = {s_reg.shift[6:0], s_reg.sda_s[1]};
          s_next.cnt = s_reg.cnt + 4'h1;
          s_next.byte_rdy = s_reg.cnt == 4'h7;
        end
        else if (scl_fall && s_reg.byte_rdy)
        begin
          s_next.byte_rdy = 1'b0;
          s_next.cnt = 4'h0;
          s_next.sda_oe = 1'b1;
          s_next.st = ACK_W;
          if (s_reg.st == ADDR)
          begin
            s_next.rw = s_reg.shift[0];
            s_next.st = ACK_ADDR;
            if (s_reg.shift[7:1] != mlsc_pkg::DEV_ADDR)
            begin
              s_next.sda_oe = 1'b0;
              s_next.st = IDLE;
            end
          end
          else if (s_reg.st == WPTR)
            s_next.ptr = s_reg.shift;
          else
          begin
            if (s_reg.ptr == mlsc_pkg::OFS_TXDIS)
              s_next.tx_soft = s_reg.shift[3:0];
            s_next.ptr = s_reg.ptr + 8'h01;
          end
        end
      ACK_ADDR, ACK_W, ACK_R:
        if (scl_rise && s_reg.st == ACK_R)
          s_next.nack = s_reg.sda_s[1];
        else if (scl_fall)
        begin
          s_next.sda_oe = 1'b0;
          s_next.st = (s_reg.st == ACK_ADDR) ? WPTR : WDATA;
          if ((s_reg.st == ACK_ADDR && s_reg.rw) ||
              (s_reg.st == ACK_R && !s_reg.nack))
          begin
            // Read mux, monitor values and flags visible to host
            case (s_reg.ptr)
              mlsc_pkg::OFS_ID: rd = mlsc_pkg::ID_VALUE;
              mlsc_pkg::OFS_STATUS:
                rd[mlsc_pkg::BIT_NOT_READY] = s_reg.not_ready;
              mlsc_pkg::OFS_FLAGS:
                rd = {3'h0, s_reg.done_flag, s_reg.los_flag};
              mlsc_pkg::OFS_TXDIS: rd = {4'h0, s_reg.tx_soft};
              default:
                if (s_reg.ptr >= mlsc_pkg::OFS_RXPWR0 &&
                    s_reg.ptr < mlsc_pkg::OFS_RXPWR0 + 8'h04)
                  rd = lane_pwr(2'(s_reg.ptr - mlsc_pkg::OFS_RXPWR0));
            endcase
            if (s_reg.ptr == mlsc_pkg::OFS_FLAGS)
            begin
              s_next.los_flag = 4'h0;
              s_next.done_flag = s_next.done_flag & !s_reg.done_flag;
            end
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.shift = {rd[6:0], 1'b0};
            s_next.sda_oe = !rd[7];
            s_next.cnt = 4'h1;
            s_next.st = RDATA;
          end
          else if (s_reg.st == ACK_R)
            s_next.st = IDLE;
        end
      RDATA:
        if (scl_fall)
        begin
          if (s_reg.cnt == 4'h8)
          begin
            s_next.sda_oe = 1'b0;
            s_next.st = ACK_R;
          end
          else
          begin
            s_next.sda_oe = !s_reg.shift[7];
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.cnt = s_reg.cnt + 4'h1;
          end
        end
      default:
        s_next.st = IDLE;
    endcase
    if (start)
    begin
      s_next.st = ADDR;
      s_next.cnt = 4'h0;
      s_next.byte_rdy = 1'b0;
      s_next.sda_oe = 1'b0;
    end
    if (stop)
      s_next.st = IDLE;
    // Deselected module drops any transfer and releases the data line
    if (s_reg.sel_s[1])
    begin
      s_next.st = IDLE;
      s_next.sda_oe = 1'b0;
    end
    // New events after the clear so a simultaneous set is kept
    s_next.los_flag = s_next.los_flag | (los_now & ~s_reg.los);
    if (soft_rst)
    begin
      s_next.tx_soft = mlsc_pkg::TXDIS_RST;
      s_next.not_ready = 1'b1;
      s_next.init_cnt = 32'h0;
      s_next.done_flag = 1'b0;
      s_next.los_flag = 4'h0;
      s_next.st = IDLE;
      s_next.sda_oe = 1'b0;
    end
    s_next.irq = s_reg.done_flag | (|s_reg.los_flag);
    s_next.tx_off = s_reg.tx_soft | {4{s_reg.txd_s[1]}};
    // Held high until ready, so no full power during init
    s_next.low_pwr = s_reg.lp_s[1] | s_reg.not_ready;
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      s_reg <= '0;
      s_reg.sel_s <= 2'h3;
      s_reg.mrst_s <= 2'h3;
      s_reg.scl_s <= 3'h7;
      s_reg.sda_s <= 3'h7;
      s_reg.not_ready <= 1'b1;
      s_reg.low_pwr <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SDA_O = 1'b0;
  assign SDA_OE_O = s_reg.sda_oe;
  assign RECEIVE_SIGNAL_LOST_O = s_reg.los_out;
  assign IRQ_N_O = 1'b0;
  assign IRQ_N_OE_O = s_reg.irq;
  assign PRESENT_N_O = 1'b0;
  assign TX_OFF_O = s_reg.tx_off;
  assign LOW_POWER_O = s_reg.low_pwr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sel_gate_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_reg.sel_s[1] |=> !SDA_OE_O && s_reg.st == IDLE)
  else $error("serial line driven while deselected");

  reset_defaults_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    soft_rst |=> s_reg.tx_soft == mlsc_pkg::TXDIS_RST && s_reg.not_ready)
  else $error("filtered reset did not restore defaults");

  done_irq_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    $fell(s_reg.not_ready) |-> s_reg.done_flag ##1 IRQ_N_OE_O)
  else $error("reset end did not post interrupt");

  powerup_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_reg.not_ready && !soft_rst
      && s_reg.init_cnt >= 32'(INIT_CYCLES - 1)
      |=> !s_reg.not_ready && s_reg.done_flag)
  else $error("init timer end not reported");

  irq_pin_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (s_reg.done_flag || s_reg.los_flag != 4'h0) |=> IRQ_N_OE_O)
  else $error("pending flag without interrupt");

  los_out_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    ##1 RECEIVE_SIGNAL_LOST_O == (|$past(los_now)))
  else $error("loss alarm does not follow lanes");

  tx_off_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_reg.txd_s[1] |=> TX_OFF_O == 4'hF)
  else $error("hardware disable ignored");

  low_power_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_reg.lp_s[1] |=> LOW_POWER_O)
  else $error("low power request ignored");

  present_a:
  assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !PRESENT_N_O)
  else $error("presence line not low");
endmodule

// ### mlsc_pkg.sv
// Behaviour
// - Serial answers only while select held low
// - Long reset pulse restores all defaults but the register pointer
// - Reset end posts interrupt, not-ready cleared
// - Power-up posts reset-complete interrupt unprompted
// - Interrupt pin low flags fault or status
// - Loss alarm when any lane under threshold
// - Transmitter off by pin or serial
// - Lane receive power readable over serial
// - Low-power input limits power consumption
// - Presence line pulled low while inserted
package mlsc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_TIME_MS = 2000;
  localparam int INIT_CYCLES = INIT_TIME_MS * CLK_MHZ * 1000;
  // ----------------------------------------------------------------
  // Serial map
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_FLAGS = 8'h03;
  localparam logic [7:0] OFS_RXPWR0 = 8'h22;
  localparam logic [7:0] OFS_TXDIS = 8'h56;
  localparam int BIT_NOT_READY = 0;
  localparam int BIT_DONE_FLAG = 4;
  localparam int LANES = 4;
  // Arbitrary identifier value
  localparam logic [7:0] ID_VALUE = 8'h5A;
  localparam logic [3:0] TXDIS_RST = 4'h0;
  localparam logic [7:0] LOS_THRESHOLD = 8'h10;
endpackage

// ### mlsc_reset_filter.sv
`timescale 1ns/10ps
module mlsc_reset_filter #(
  parameter int MIN_CYCLES = mlsc_pkg::RESET_MIN_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_n_i,
  output logic fire_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic fire;
  } mlsc_flt_t;

  mlsc_flt_t s_reg;
  mlsc_flt_t s_next;

  // ----------------------------------------------------------------
  // Low-time counter
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.fire = 1'b0;
    if (level_n_i)
      s_next.cnt = 32'h0;
    else if (s_reg.cnt != 32'(MIN_CYCLES))
    begin
      s_next.cnt = s_reg.cnt + 32'h1;
      // Fires once per low period, short glitches never get here
      if (s_next.cnt == 32'(MIN_CYCLES))
        s_next.fire = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign fire_o = s_reg.fire;

  short_pulse_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(s_reg.fire) |-> !$past(level_n_i) && s_reg.cnt == 32'(MIN_CYCLES))
  else $error("reset fired before minimum low time");
endmodule

// ### mlsc_host_model.sv
`timescale 1ns/10ps
module mlsc_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ----------------------------------------
  // Bus primitives
  // ----------------------------------------
  initial scl_o = 1'b1;
  initial sda_low_o = 1'b0;
  // Eight clocks a phase, three phases a bit, keeps SCL slow enough
  task automatic hp();
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b0;
    hp();
  endtask
  // SDA moves only while SCL low, never on the SCL edge
  task automatic bit_io(input logic b, output logic s);
    sda_low_o = !b;
    hp();
    scl_o = 1'b1;
    hp();
    s = sda_i;
    scl_o = 1'b0;
    hp();
  endtask
  // Source of an interrupt is found by reading the map
  task automatic byte_io(input logic [7:0] d, input logic mack,
                         output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(!mack, s);
    ack = !s;
  endtask
endmodule

// ### test_module_low_speed_control.sv
`timescale 1ns/10ps
module test_module_low_speed_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel_n = 1'b0;
  logic mrst_n = 1'b1;
  logic lp = 1'b0;
  logic txd = 1'b0;
  logic [31:0] rxp = 32'h40404040;
  logic scl, h_low, sda, sda_o, sda_oe, rsl, irq_o, irq_oe, prs, lpo;
  logic [3:0] txoff;
  int fails = 0;
  int compares = 0;
  // Open-drain data line with pull-up
  assign sda = !h_low & (sda_oe ? sda_o : 1'b1);
  always #2.5 clk = !clk;
  mlsc_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl),
    .sda_low_o(h_low));
  mlsc_top #(.INIT_CYCLES(20), .RESET_MIN_CYCLES(4)) DUT (
    .CLOCK_I(clk), .RESET_I(rst), .DEVICE_SELECT_N_I(sel_n),
    .MODULE_RESET_N_I(mrst_n), .LOW_POWER_REQUEST_I(lp),
    .TRANSMIT_DISABLE_I(txd), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .RX_POWER_I(rxp),
    .RECEIVE_SIGNAL_LOST_O(rsl), .IRQ_N_O(irq_o),
    .IRQ_N_OE_O(irq_oe), .PRESENT_N_O(prs), .TX_OFF_O(txoff),
    .LOW_POWER_O(lpo));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    logic [7:0] x;
    logic a;
    host.start();
    host.byte_io(8'hA0, 1'b0, x, a);
    host.byte_io(o, 1'b0, x, a);
    host.byte_io(d, 1'b0, x, a);
    chk("wr_ack", 8'h01, {7'h00, a});
    host.stop();
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] q);
    logic [7:0] x;
    logic a;
    host.start();
    host.byte_io(8'hA0, 1'b0, x, a);
    chk("addr_ack", 8'h01, {7'h00, a});
    host.byte_io(o, 1'b0, x, a);
    host.start();
    host.byte_io(8'hA1, 1'b0, x, a);
    host.byte_io(8'hFF, 1'b0, q, a);
    host.stop();
  endtask
  // Status is only trusted once the interrupt is posted
  task automatic wait_irq();
    for (int i = 0; i < 400 && irq_oe !== 1'b1; i++)
      tick(1);
    chk("irq_wait", 8'h01, {7'h00, irq_oe});
    if (irq_oe !== 1'b1)
      tally_and_finish();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_powerup();
    logic [7:0] q;
    chk("low_power_init", 8'h01, {7'h00, lpo});
    chk("irq_in_init", 8'h00, {7'h00, irq_oe});
    chk("irq_level", 8'h00, {7'h00, irq_o});
    chk("sda_level", 8'h00, {7'h00, sda_o});
    chk("present_n", 8'h00, {7'h00, prs});
    wait_irq();
    rd(8'h02, q);
    chk("not_ready", 8'h00, q);
    rd(8'h03, q);
    chk("flags_done", 8'h10, q);
    tick(3);
    chk("irq_cleared", 8'h00, {7'h00, irq_oe});
    $display("t_powerup done");
  endtask
  task automatic t_select();
    logic [7:0] x;
    logic a;
    sel_n = 1'b1;
    tick(3);
    host.start();
    host.byte_io(8'hA0, 1'b0, x, a);
    chk("deselected_ack", 8'h00, {7'h00, a});
    host.stop();
    sel_n = 1'b0;
    tick(3);
    rd(8'h00, x);
    chk("id", 8'h5A, x);
    $display("t_select done");
  endtask
  task automatic t_tx();
    txd = 1'b1;
    tick(5);
    chk("tx_hw", 8'h0F, {4'h0, txoff});
    txd = 1'b0;
    wr(8'h56, 8'h05);
    tick(2);
    chk("tx_soft", 8'h05, {4'h0, txoff});
    txd = 1'b1;
    tick(5);
    chk("tx_both", 8'h0F, {4'h0, txoff});
    txd = 1'b0;
    tick(5);
    chk("tx_soft_kept", 8'h05, {4'h0, txoff});
    $display("t_tx done");
  endtask
  task automatic t_los();
    logic [7:0] q;
    logic a;
    rxp = 32'h100F3340;
    tick(4);
    chk("los_set", 8'h01, {7'h00, rsl});
    chk("los_irq", 8'h01, {7'h00, irq_oe});
    rd(8'h03, q);
    chk("los_flag", 8'h04, q);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h22 + 8'(i), q);
      chk("lane_power", rxp[i*8 +: 8], q);
    end
    // Master ack keeps the pointer running across lanes
    host.start();
    host.byte_io(8'hA0, 1'b0, q, a);
    host.byte_io(8'h22, 1'b0, q, a);
    host.start();
    host.byte_io(8'hA1, 1'b0, q, a);
    for (int i = 0; i < 4; i++)
    begin
      host.byte_io(8'hFF, i < 3, q, a);
      chk("burst_power", rxp[i*8 +: 8], q);
    end
    host.stop();
    rxp = 32'h10101010;
    tick(4);
    chk("los_threshold", 8'h00, {7'h00, rsl});
    $display("t_los done");
  endtask
  task automatic t_lp();
    lp = 1'b1;
    tick(5);
    chk("lp_on", 8'h01, {7'h00, lpo});
    lp = 1'b0;
    tick(5);
    chk("lp_off", 8'h00, {7'h00, lpo});
    $display("t_lp done");
  endtask
  task automatic t_mrst();
    logic [7:0] q;
    mrst_n = 1'b0;
    tick(3);
    mrst_n = 1'b1;
    tick(8);
    chk("short_reset", 8'h05, {4'h0, txoff});
    mrst_n = 1'b0;
    tick(12);
    mrst_n = 1'b1;
    wait_irq();
    chk("reset_tx", 8'h00, {4'h0, txoff});
    rd(8'h56, q);
    chk("reset_soft", 8'h00, q);
    rd(8'h03, q);
    chk("reset_flags", 8'h10, q);
    $display("t_mrst done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    tick(10);
    rst = 1'b0;
    tick(1);
    t_powerup();
    t_select();
    t_tx();
    t_los();
    t_lp();
    t_mrst();
    tally_and_finish();
  end
endmodule
